// [src/gfpc_pkg.sv]
// Package for the gated frequency/period counter: register map, field layout,
// reset values, timing counts and shared types.
// Assumes a single 25 MHz reference clock and word-indexed register addresses.
package gfpc_pkg;

   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int DIGITS = 8;
   localparam int GCNT_W = 24;

   // Register addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GATE = 8'h01;
   localparam logic [7:0] ADDR_PRESC = 8'h02;
   localparam logic [7:0] ADDR_NORM = 8'h03;
   localparam logic [7:0] ADDR_PRESET = 8'h04;
   localparam logic [7:0] ADDR_RAW = 8'h05;
   localparam logic [7:0] ADDR_RESULT = 8'h06;
   localparam logic [7:0] ADDR_INT_STAT = 8'h07;
   localparam logic [7:0] ADDR_INT_CLR = 8'h08;
   localparam logic [7:0] ADDR_INT_EN = 8'h09;
   localparam logic [7:0] ADDR_STATE = 8'h0A;

   // Field layout
   localparam int CTRL_W = 6;
   localparam int INT_W = 2;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_OVER_BIT = 1;
   localparam int NORM_FRAC = 8;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [15:0] GATE_RST = 16'h03E8;
   localparam logic [7:0] PRESC_RST = 8'h01;
   localparam logic [15:0] NORM_RST = 16'h0100;
   localparam logic [31:0] PRESET_RST = 32'hFFFFFFFF;

   // Averaging counts, decade steps
   localparam logic [GCNT_W-1:0] AVG_N0 = 24'h000001;
   localparam logic [GCNT_W-1:0] AVG_N1 = 24'h00000A;
   localparam logic [GCNT_W-1:0] AVG_N2 = 24'h000064;
   localparam logic [GCNT_W-1:0] AVG_N3 = 24'h0003E8;

   // Time base tick
   localparam int REF_CLK_NS = 40;
   localparam int TB_TICK_NS = 1000;
   localparam int TB_TICK_CYC = (TB_TICK_NS / REF_CLK_NS < 1) ? 1 : TB_TICK_NS / REF_CLK_NS;
   localparam int TB_CNT_W = 5;
   localparam logic [TB_CNT_W-1:0] TB_LAST = 5'(TB_TICK_CYC - 1);

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } gfpc_bus_req_t;

   typedef struct packed {
      logic [1:0] avg_exp;
      logic preset_en;
      logic norm_en;
      logic mode;
      logic run;
   } gfpc_ctrl_t;

   typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_OPEN, ST_DONE} gfpc_state_t;

endpackage

// [src/gfpc_decade_counter_stage.sv]
// One decimal decade counter stage of the accumulation chain.
// Assumes clear and increment come from logic on the same clock.
`timescale 1ns/10ps
module gfpc_decade_counter_stage (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Control
   input wire logic clr,
   input wire logic inc,
   // Digit and carry
   output logic [3:0] digit_q,
   output logic carry
);
   logic [3:0] digit_d;

   always_comb begin
      carry = inc && (digit_q == 4'h9);
      digit_d = digit_q;
      if (clr) begin
         digit_d = 4'h0;
      end else if (carry) begin
         digit_d = 4'h0;
      end else if (inc) begin
         digit_d = digit_q + 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         digit_q <= 4'h0;
      end else begin
         digit_q <= digit_d;
      end
   end
endmodule // gfpc_decade_counter_stage

// [src/gfpc_top.sv]
// Gated frequency/period counter with decade chain, prescaler, averaging,
// normalizing, preset compare and a plain register port.
// Assumes sig_in is asynchronous to ref_clk; bus master is on ref_clk.
// How it works
// [R1] Frequency mode: one count per conditioned input cycle while the gate is open.
// [R2] Period mode: count clock pulses; the input edges open and close the gate.
// [R3] Counts accumulate in cascaded decade stages, each carrying into the next.
// [R4] Averaging holds the gate over n periods, n in decades, result divided by n; in frequency mode the count is divided by n but the gate is not held longer.
// [R5] Prescale by n divides the input and stretches the gate time by n; the code applies it in frequency mode only, period mode ignores it.
// [R6] Normalizing shows the result times a user constant, multiplied digitally.
// [R7] Preset output asserts when the shown result exceeds the preset number.
// [R8] Preset compare acts on the normalized result when both are enabled.
// [R9] Compare and result latch happen once per finished gate, never mid-count.
`timescale 1ns/10ps
module gfpc_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   input gfpc_pkg::gfpc_bus_req_t bus_req,
   output logic [gfpc_pkg::DATA_W-1:0] rd_data_q,
   // Measured signal
   input wire logic sig_in,
   // Outputs
   output logic gate_open_q,
   output logic preset_out_q,
   output logic irq_q
);
   import gfpc_pkg::*;

   gfpc_ctrl_t ctrl_q, ctrl_d;
   logic [15:0] gate_q, gate_d;
   logic [7:0] presc_q, presc_d;
   logic [15:0] norm_q, norm_d;
   logic [31:0] preset_q, preset_d;
   logic [INT_W-1:0] int_en_q, int_en_d, status_q, status_d;
   gfpc_state_t st_q, st_d;
   logic [GCNT_W-1:0] gcnt_q, gcnt_d;
   logic [TB_CNT_W-1:0] tb_q, tb_d;
   logic [7:0] pre_q, pre_d;
   logic [31:0] raw_q, raw_d, result_q, result_d;
   logic gate_open_d, preset_out_d, irq_d;
   logic [DATA_W-1:0] rd_data_d;
   logic sig_meta_q, sig_sync_q, sig_prev_q;

   logic in_edge, tb_tick, pre_pulse, chain_clr, chain_inc;
   logic [7:0] presc_eff;
   logic [15:0] gate_eff;
   logic [GCNT_W-1:0] avg_n, gate_len;
   logic [DIGITS*4-1:0] chain_bcd, avg_bcd;
   logic [DIGITS:0] carry_in;
   logic [31:0] bin_val, norm_val, disp_val;
   logic [47:0] prod;
   logic over;

   // Input synchroniser and edge detect
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sig_meta_q <= 1'b0;
         sig_sync_q <= 1'b0;
         sig_prev_q <= 1'b0;
      end else begin
         sig_meta_q <= sig_in;
         sig_sync_q <= sig_meta_q;
         sig_prev_q <= sig_sync_q;
      end
   end
   assign in_edge = sig_sync_q && !sig_prev_q;

   // Decade counter chain
   assign carry_in[0] = chain_inc;
   genvar gi;
   generate
      for (gi = 0; gi < DIGITS; gi++) begin : g_dec
         gfpc_decade_counter_stage u_stage (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .clr(chain_clr),
            .inc(carry_in[gi]), // [R3]
            .digit_q(chain_bcd[gi*4 +: 4]),
            .carry(carry_in[gi+1])
         );
      end
   endgenerate

   function automatic logic [31:0] bcd2bin(input logic [DIGITS*4-1:0] bcd);
      logic [31:0] acc;
      acc = 32'h0;
      for (int i = DIGITS - 1; i >= 0; i--) begin
         acc = 32'((acc * 32'd10) + {28'h0, bcd[i*4 +: 4]});
      end
      return acc;
   endfunction

   // Result path
   always_comb begin
      presc_eff = (presc_q == 8'h00) ? 8'h01 : presc_q;
      gate_eff = (gate_q == 16'h0000) ? 16'h0001 : gate_q;
      gate_len = GCNT_W'(gate_eff * presc_eff); // [R5]
      unique case (ctrl_q.avg_exp)
         2'd0: avg_n = AVG_N0;
         2'd1: avg_n = AVG_N1;
         2'd2: avg_n = AVG_N2;
         2'd3: avg_n = AVG_N3;
      endcase
      avg_bcd = chain_bcd >> {ctrl_q.avg_exp, 2'b00}; // [R4]
      bin_val = bcd2bin(avg_bcd);
      prod = bin_val * norm_q; // [R6]
      norm_val = (|prod[47:32+NORM_FRAC]) ? 32'hFFFFFFFF : prod[NORM_FRAC +: 32];
      disp_val = ctrl_q.norm_en ? norm_val : bin_val;
      over = ctrl_q.preset_en && (disp_val > preset_q); // [R7] [R8]
   end

   assign tb_tick = (tb_q == TB_LAST);
   assign pre_pulse = in_edge && (pre_q == presc_eff - 8'h01); // [R5]
   assign chain_clr = (st_q == ST_IDLE) && ctrl_q.run;
   assign chain_inc = (st_q == ST_OPEN) && (ctrl_q.mode ? 1'b1 : pre_pulse); // [R1] [R2]

   // Control, measurement and registers
   always_comb begin
      ctrl_d = ctrl_q;
      gate_d = gate_q;
      presc_d = presc_q;
      norm_d = norm_q;
      preset_d = preset_q;
      int_en_d = int_en_q;
      status_d = status_q;
      st_d = st_q;
      gcnt_d = gcnt_q;
      raw_d = raw_q;
      result_d = result_q;
      preset_out_d = preset_out_q;
      tb_d = tb_tick ? '0 : tb_q + 5'h01;
      pre_d = pre_q;
      if (st_q != ST_OPEN) begin
         pre_d = 8'h00;
      end else if (in_edge) begin
         pre_d = pre_pulse ? 8'h00 : pre_q + 8'h01;
      end
      unique case (st_q)
         ST_IDLE: begin
            if (ctrl_q.run) begin
               st_d = ST_ARM;
            end
         end
         ST_ARM: begin
            if (!ctrl_q.run) begin
               st_d = ST_IDLE;
            end else if (ctrl_q.mode && in_edge) begin
               st_d = ST_OPEN; // [R2]
               gcnt_d = avg_n; // [R4]
            end else if (!ctrl_q.mode && tb_tick) begin
               st_d = ST_OPEN;
               gcnt_d = gate_len; // [R5]
            end
         end
         ST_OPEN: begin
            if (!ctrl_q.run) begin
               st_d = ST_IDLE;
            end else if (ctrl_q.mode ? in_edge : tb_tick) begin
               if (gcnt_q == 24'h000001) begin
                  st_d = ST_DONE; // [R2] [R4]
               end else begin
                  gcnt_d = gcnt_q - 24'h000001;
               end
            end
         end
         ST_DONE: begin
            raw_d = avg_bcd; // [R9]
            result_d = disp_val; // [R6] [R9]
            preset_out_d = over; // [R7] [R9]
            status_d[INT_DONE_BIT] = 1'b1;
            status_d[INT_OVER_BIT] = status_q[INT_OVER_BIT] | over;
            st_d = ST_IDLE;
         end
      endcase
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            ADDR_CTRL: ctrl_d = bus_req.wdata[CTRL_W-1:0];
            ADDR_GATE: gate_d = bus_req.wdata[15:0];
            ADDR_PRESC: presc_d = bus_req.wdata[7:0];
            ADDR_NORM: norm_d = bus_req.wdata[15:0];
            ADDR_PRESET: preset_d = bus_req.wdata;
            ADDR_INT_EN: int_en_d = bus_req.wdata[INT_W-1:0];
            ADDR_INT_CLR: status_d = status_q & ~bus_req.wdata[INT_W-1:0];
            default: ;
         endcase
         if (bus_req.addr == ADDR_INT_CLR && st_q == ST_DONE) begin
            status_d[INT_DONE_BIT] = 1'b1;
            status_d[INT_OVER_BIT] = status_d[INT_OVER_BIT] | over;
         end
      end
      gate_open_d = (st_d == ST_OPEN);
      irq_d = |(status_q & int_en_q);
      rd_data_d = '0;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            ADDR_CTRL: rd_data_d = {26'h0, ctrl_q};
            ADDR_GATE: rd_data_d = {16'h0, gate_q};
            ADDR_PRESC: rd_data_d = {24'h0, presc_q};
            ADDR_NORM: rd_data_d = {16'h0, norm_q};
            ADDR_PRESET: rd_data_d = preset_q;
            ADDR_RAW: rd_data_d = raw_q;
            ADDR_RESULT: rd_data_d = result_q;
            ADDR_INT_STAT: rd_data_d = {30'h0, status_q};
            ADDR_INT_EN: rd_data_d = {30'h0, int_en_q};
            ADDR_STATE: rd_data_d = {28'h0, st_q, preset_out_q, gate_open_q};
            default: rd_data_d = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RST;
         gate_q <= GATE_RST;
         presc_q <= PRESC_RST;
         norm_q <= NORM_RST;
         preset_q <= PRESET_RST;
         int_en_q <= '0;
         status_q <= '0;
         st_q <= ST_IDLE;
         gcnt_q <= '0;
         tb_q <= '0;
         pre_q <= 8'h00;
         raw_q <= 32'h0;
         result_q <= 32'h0;
         gate_open_q <= 1'b0;
         preset_out_q <= 1'b0;
         irq_q <= 1'b0;
         rd_data_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         gate_q <= gate_d;
         presc_q <= presc_d;
         norm_q <= norm_d;
         preset_q <= preset_d;
         int_en_q <= int_en_d;
         status_q <= status_d;
         st_q <= st_d;
         gcnt_q <= gcnt_d;
         tb_q <= tb_d;
         pre_q <= pre_d;
         raw_q <= raw_d;
         result_q <= result_d;
         gate_open_q <= gate_open_d;
         preset_out_q <= preset_out_d;
         irq_q <= irq_d;
         rd_data_q <= rd_data_d;
      end
   end

   // Checks
   AST_FREQ_COUNT: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R1]
      (st_q == ST_OPEN && !ctrl_q.mode && pre_pulse && chain_bcd[3:0] != 4'h9)
      |=> chain_bcd[3:0] == $past(chain_bcd[3:0]) + 4'h1)
      else $error("frequency count did not advance");
   AST_PERIOD_OPEN: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R2]
      (st_q == ST_ARM && ctrl_q.run && ctrl_q.mode && in_edge)
      |=> st_q == ST_OPEN ##1 gate_open_q)
      else $error("period gate did not open on input edge");
   AST_CARRY: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R3]
      (chain_inc && !chain_clr && chain_bcd[3:0] == 4'h9 && chain_bcd[7:4] != 4'h9)
      |=> chain_bcd[3:0] == 4'h0 && chain_bcd[7:4] == $past(chain_bcd[7:4]) + 4'h1)
      else $error("decade carry lost");
   AST_AVG: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R4]
      (st_q == ST_DONE && ctrl_q.avg_exp == 2'd2)
      |=> raw_q == ($past(chain_bcd) >> 8))
      else $error("averaged result not divided by n");
   AST_PRESC_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R5]
      (st_q == ST_ARM && ctrl_q.run && !ctrl_q.mode && tb_tick)
      |=> gcnt_q == GCNT_W'($past(gate_eff) * $past(presc_eff)))
      else $error("gate time not stretched by prescale");
   AST_NORM: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R6]
      (st_q == ST_DONE && ctrl_q.norm_en) |=> result_q == $past(norm_val))
      else $error("normalized result wrong");
   AST_PRESET: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
      (st_q == ST_DONE && ctrl_q.preset_en && disp_val > preset_q) |=> preset_out_q)
      else $error("preset output missed");
   AST_PRESET_NORM: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R8]
      (st_q == ST_DONE && ctrl_q.norm_en && ctrl_q.preset_en)
      |=> preset_out_q == ($past(norm_val) > $past(preset_q)))
      else $error("preset did not compare normalized value");
   AST_LATCH_DONE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R9]
      (st_q != ST_DONE) |=> $stable(result_q) && $stable(preset_out_q))
      else $error("result changed outside gate end");
   AST_PERIOD_CLOSE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R2] [R4]
      (st_q == ST_OPEN && ctrl_q.run && ctrl_q.mode && in_edge && gcnt_q == 24'h000001)
      |=> st_q == ST_DONE && !gate_open_q)
      else $error("period gate did not close after n periods");
   AST_CHAIN_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R3]
      (!chain_inc && !chain_clr) |=> $stable(chain_bcd))
      else $error("decade chain moved with no count");
   AST_PRESET_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
      (st_q == ST_DONE && !ctrl_q.preset_en) |=> !preset_out_q)
      else $error("preset output set while compare disabled");
   AST_DONE_SET: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R9]
      (st_q == ST_DONE) |=> status_q[INT_DONE_BIT])
      else $error("done status lost at gate end");

endmodule // gfpc_top

// [dv/gfpc_sig_src.sv]
// Signal source standing in for the input trigger stage: a square wave on sig_in.
// Assumes a half period of at least one ref_clk cycle; idles low while disabled.
`timescale 1ns/10ps
module gfpc_sig_src (
   // Clock
   input wire logic ref_clk,
   // Control
   input wire logic en,
   input wire logic [15:0] half_cyc,
   // Conditioned input
   output logic sig_in = 1'b0
);
   logic [15:0] cnt_q = 16'h0000;

   // Toggle every half period, stand still low when off
   always @(posedge ref_clk) begin
      if (en !== 1'b1) begin
         cnt_q <= 16'h0000;
         sig_in <= 1'b0;
      end else if (cnt_q + 16'h0001 >= half_cyc) begin
         cnt_q <= 16'h0000;
         sig_in <= ~sig_in;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule // gfpc_sig_src

// [dv/gfpc_top_tb_top.sv]
// Testbench for the gated frequency/period counter: register tasks and measurements.
// Assumes the square wave source model and the design package and top module.
`timescale 1ns/10ps
module gfpc_top_tb_top;
   import gfpc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   gfpc_bus_req_t bus = '0;
   logic [DATA_W-1:0] rd_data_q;
   logic sig_in, gate_open_q, preset_out_q, irq_q;
   logic src_en = 1'b0;
   logic [15:0] src_half = 16'h0005;
   logic po_last = 1'b0;
   logic mid_chg = 1'b0;
   int fail_count = 0;
   int comparisons = 0;
   int run_len = 0;
   int last_len = 0;
   int glen = 0;
   logic [31:0] rdv, raw_v, res_v;
   logic [7:0] rst_a[8] = '{ADDR_CTRL, ADDR_GATE, ADDR_PRESC, ADDR_NORM, ADDR_PRESET,
      ADDR_INT_EN, ADDR_INT_CLR, 8'h20};
   logic [31:0] rst_v[8] = '{32'h0, 32'(GATE_RST), 32'(PRESC_RST), 32'(NORM_RST),
      PRESET_RST, 32'h0, 32'h0, 32'h0};

   always #20 ref_clk = ~ref_clk;

   gfpc_top gfpc_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus),
      .rd_data_q(rd_data_q), .sig_in(sig_in), .gate_open_q(gate_open_q),
      .preset_out_q(preset_out_q), .irq_q(irq_q));
   gfpc_sig_src gfpc_sig_src_i (.ref_clk(ref_clk), .en(src_en), .half_cyc(src_half),
      .sig_in(sig_in));

   // Gate length and preset output movement while counting
   always @(posedge ref_clk) begin
      po_last <= preset_out_q;
      if (gate_open_q === 1'b1 && preset_out_q !== po_last) begin
         mid_chg <= 1'b1;
      end
      if (gate_open_q === 1'b1) begin
         run_len <= run_len + 1;
      end else if (run_len != 0) begin
         last_len <= run_len;
         run_len <= 0;
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_near(input string name, input int exp, input logic [31:0] got);
      comparisons++;
      if ((^got) === 1'bx || got + 32'h1 < 32'(exp) || got > 32'(exp + 1)) begin
         fail_count++;
         $display("FAIL %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      d = rd_data_q;
   endtask

   function automatic int bcd2bin(input logic [31:0] b);
      int v;
      v = 0;
      for (int i = 7; i >= 0; i--) v = v * 10 + int'(b[4*i +: 4]);
      return v;
   endfunction

   // One gate interval with the done interrupt, then stop and read back
   task automatic measure(input logic [31:0] ctrl);
      int n;
      n = 0;
      wr(ADDR_INT_CLR, 32'h3);
      wr(ADDR_INT_EN, 32'h1);
      wr(ADDR_CTRL, ctrl | 32'h1);
      while (irq_q !== 1'b1 && n < 30000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      glen = last_len;
      chk("done interrupt", 32'h1, {31'h0, irq_q});
      wr(ADDR_CTRL, ctrl);
      rd(ADDR_RAW, raw_v);
      rd(ADDR_RESULT, res_v);
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge ref_clk);
      fail_count++;
      finish_test();
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      // Reset values, unmapped place ignored
      wr(8'h20, 32'hFFFFFFFF);
      foreach (rst_a[i]) begin
         rd(rst_a[i], rdv);
         chk("reset value", rst_v[i], rdv);
      end
      // Frequency mode, with and without prescaling
      src_en <= 1'b1;
      wr(ADDR_GATE, 32'h4);
      for (int p = 1; p <= 2; p++) begin
         wr(ADDR_PRESC, 32'(p));
         measure(32'h0);
         chk("gate cycles", 32'(100 * p), 32'(glen));
         chk_near("freq count", 10, res_v);
         chk("decade result", res_v, 32'(bcd2bin(raw_v)));
      end
      // Period mode over 1, 10 and 100 periods
      wr(ADDR_PRESC, 32'h1);
      src_half <= 16'h0032;
      for (int e = 0; e <= 2; e++) begin
         measure(32'h2 | (32'(e) << 4));
         chk_near("period gate", 100 * 10 ** e, 32'(glen));
         chk_near("period count", 100, res_v);
         chk("decade result", res_v, 32'(bcd2bin(raw_v)));
      end
      // Normalized result compared with two presets
      src_half <= 16'h0005;
      wr(ADDR_NORM, 32'h280);
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_PRESET, k ? 32'h20 : 32'h14);
         measure(32'hC);
         chk("normalized", 32'((bcd2bin(raw_v) * 640) >> 8), res_v);
         chk("preset out", {31'h0, res_v > (k ? 32'h20 : 32'h14)}, {31'h0, preset_out_q});
         rd(ADDR_INT_STAT, rdv);
         chk("over status", k ? 32'h1 : 32'h3, rdv);
      end
      chk("preset still while open", 32'h0, {31'h0, mid_chg});
      // Read-only result, interrupt status, mask and clear
      wr(ADDR_RESULT, 32'h0);
      rd(ADDR_RESULT, rdv);
      chk("read-only result", res_v, rdv);
      rd(ADDR_INT_STAT, rdv);
      chk("int status", 32'h1, rdv);
      wr(ADDR_INT_EN, 32'h0);
      @(posedge ref_clk);
      #1;
      chk("masked irq", 32'h0, {31'h0, irq_q});
      wr(ADDR_INT_CLR, 32'h3);
      rd(ADDR_INT_STAT, rdv);
      chk("cleared status", 32'h0, rdv);
      finish_test();
   end
endmodule // gfpc_top_tb_top
